// ===== ubbp_defs.vh
// Constants for the bit-bang port: bus map, mode codes, field positions, timing.
// Included by the port and its bench; holds definitions only.
`ifndef UBBP_DEFS_VH
`define UBBP_DEFS_VH

// Register byte offsets on the Wishbone slave
`define UBBP_REG_MODE       4'h0
`define UBBP_REG_DIR        4'h4
`define UBBP_REG_DATA       4'h8
`define UBBP_REG_SAMPLE     4'hc

// Mode command values
`define UBBP_MODE_RESET     8'h00
`define UBBP_MODE_ASYNC     8'h01
`define UBBP_MODE_SYNC      8'h04

// Field positions in the mode register (bits above 7)
`define UBBP_MODE_PRI_LO    8
`define UBBP_MODE_PRI_HI    9
`define UBBP_MODE_CHB_BIT   10
`define UBBP_MODE_WAKE_BIT  11

// Primary channel modes
`define UBBP_PRI_FIFO       2'h0
`define UBBP_PRI_ISO        2'h1
`define UBBP_PRI_UART       2'h2

// Sample register status field positions
`define UBBP_SMP_VALID_BIT  8
`define UBBP_SMP_SUSP_BIT   9

// Reset values
`define UBBP_RST_MODE       8'h00
`define UBBP_RST_DIR        8'h00
`define UBBP_RST_DATA       8'h00

// Baud divider default: 50 MHz / 500 kHz tick, below the 1 MBd ceiling
`define UBBP_BAUD_DIV       16'h0064

`endif

// ===== ubbp_fifo.v
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/10ps
module ubbp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;
    integer         i;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    ////////////////////////////////////////////////////////////////////////
    // Pointers and occupancy; flush empties without touching storage
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end

    // Storage
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
        end else if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // ubbp_fifo

// ===== ubbp_port.v
// Bit-bang port of one bridge channel: Wishbone registers, pacing, strobes, sample FIFO.
// Assumes clk at 50 MHz, resetn asynchronous active low, pins from outside the clock domain.
`timescale 1ns/10ps
`include "ubbp_defs.vh"
module ubbp_port #(
    parameter             FIFO_DEPTH = 4,
    parameter [15:0]      BAUD_DIV   = `UBBP_BAUD_DIV
) (
    input  wire           clk,
    input  wire           resetn,
    input  wire [3:0]     wb_adr_i,
    input  wire [31:0]    wb_dat_i,
    output reg  [31:0]    wb_dat_o,
    input  wire [3:0]     wb_sel_i,
    input  wire           wb_we_i,
    input  wire           wb_cyc_i,
    input  wire           wb_stb_i,
    output reg            wb_ack_o,
    output reg            wb_err_o,
    input  wire [7:0]     bus_in,
    output reg  [7:0]     bus_out,
    output reg  [7:0]     bus_oe,
    output reg            status_wr_n,
    output reg            status_rd_n,
    output reg            alt_wr_n,
    output reg            alt_rd_n,
    input  wire           send_now_wake_in,
    input  wire           power_on_state_n,
    output reg            resume_req,
    output reg            flush_tx
);
    // Sync cycle states, one-hot
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_RDOFF = 5'h02;
    localparam [4:0] ST_DRIVE = 5'h04;
    localparam [4:0] ST_SETUP = 5'h08;
    localparam [4:0] ST_WRACT = 5'h10;

    reg  [7:0]  mode;
    reg  [1:0]  pri_mode;
    reg         chan_b;
    reg         wake_en;
    reg  [7:0]  dir;
    reg  [7:0]  data_reg;
    reg         data_new;
    reg  [15:0] baud_cnt;
    reg         baud_tick;
    reg  [4:0]  state;
    reg  [7:0]  pin_meta;
    reg  [7:0]  pin_sync;
    reg  [2:0]  wake_sr;
    reg  [1:0]  susp_sr;
    reg  [7:0]  out_val;
    reg         rd_n;
    reg         wr_n;
    reg  [7:0]  cap_byte;
    reg         cap_push;

    wire        wb_req;
    wire        wr_data;
    wire        mode_async;
    wire        mode_sync;
    wire        bb_on;
    wire        fifo_in_ready;
    wire [7:0]  fifo_out_data;
    wire        fifo_out_valid;
    wire        fifo_pop;
    wire        wake_fall;
    wire        strobe_alt;

    assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wr_data    = wb_req & wb_we_i & (wb_adr_i == `UBBP_REG_DATA) & wb_sel_i[0];
    // Channel B loses bit-bang entirely while its isolated serial mode is on
    assign bb_on      = ~(chan_b && pri_mode == `UBBP_PRI_ISO);
    assign mode_async = bb_on && (mode == `UBBP_MODE_ASYNC);
    assign mode_sync  = bb_on && (mode == `UBBP_MODE_SYNC);
    assign fifo_pop   = wb_req & ~wb_we_i & (wb_adr_i == `UBBP_REG_SAMPLE) & fifo_out_valid;
    assign wake_fall  = wake_sr[2] & ~wake_sr[1];
    assign strobe_alt = (pri_mode == `UBBP_PRI_UART);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before any logic looks at a pin
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= 8'hff;
            pin_sync <= 8'hff;
            wake_sr  <= 3'h7;
            susp_sr  <= 2'h3;
        end else begin
            pin_meta <= bus_in;
            pin_sync <= pin_meta;
            wake_sr  <= {wake_sr[1:0], send_now_wake_in};
            susp_sr  <= {susp_sr[0], power_on_state_n};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-cycle ack, error on unmapped addresses
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            mode     <= `UBBP_RST_MODE;
            pri_mode <= `UBBP_PRI_FIFO;
            chan_b   <= 1'b0;
            wake_en  <= 1'b0;
            dir      <= `UBBP_RST_DIR;
        end else begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            if (wb_req) begin
                case (wb_adr_i)
                    `UBBP_REG_MODE: begin
                        wb_ack_o <= 1'b1;
                        wb_dat_o <= {20'h00000, wake_en, chan_b, pri_mode, mode};
                        if (wb_we_i && wb_sel_i[0])
                            mode <= wb_dat_i[7:0];
                        if (wb_we_i && wb_sel_i[1]) begin
                            pri_mode <= wb_dat_i[`UBBP_MODE_PRI_HI:`UBBP_MODE_PRI_LO];
                            chan_b   <= wb_dat_i[`UBBP_MODE_CHB_BIT];
                            wake_en  <= wb_dat_i[`UBBP_MODE_WAKE_BIT];
                        end
                    end
                    `UBBP_REG_DIR: begin
                        wb_ack_o <= 1'b1;
                        wb_dat_o <= {24'h000000, dir};
                        if (wb_we_i && wb_sel_i[0])
                            dir <= wb_dat_i[7:0];
                    end
                    `UBBP_REG_DATA: begin
                        wb_ack_o <= 1'b1;
                        wb_dat_o <= {24'h000000, pin_sync};
                    end
                    `UBBP_REG_SAMPLE: begin
                        wb_ack_o <= 1'b1;
                        // Empty FIFO reads back the valid bit clear
                        wb_dat_o <= {22'h000000, susp_sr[1], fifo_out_valid, fifo_out_data};
                    end
                    default: begin
                        wb_err_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Baud tick generator paces both modes
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            baud_cnt  <= 16'h0000;
            baud_tick <= 1'b0;
        end else if (baud_cnt >= BAUD_DIV - 16'h0001) begin
            baud_cnt  <= 16'h0000;
            baud_tick <= 1'b1;
        end else begin
            baud_cnt  <= baud_cnt + 16'h0001;
            baud_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending byte and output engine for both modes
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_reg <= `UBBP_RST_DATA;
            data_new <= 1'b0;
            out_val  <= `UBBP_RST_DATA;
            rd_n     <= 1'b1;
            wr_n     <= 1'b1;
            state    <= ST_IDLE;
            cap_byte <= 8'h00;
            cap_push <= 1'b0;
        end else begin
            cap_push <= 1'b0;
            if (!mode_async && !mode_sync) begin
                // Mode 0, an unknown code or bit-bang off on channel B: back to the reset state
                data_new <= 1'b0;
                out_val  <= `UBBP_RST_DATA;
                rd_n     <= 1'b1;
                wr_n     <= 1'b1;
                state    <= ST_IDLE;
            end else if (mode_async) begin
                state <= ST_IDLE;
                rd_n  <= 1'b1;
                // Write strobe marks each paced update; low for one tick period
                if (data_new && baud_tick) begin
                    out_val  <= data_reg;
                    data_new <= 1'b0;
                    wr_n     <= 1'b0;
                end else if (baud_tick) begin
                    wr_n <= 1'b1;
                end
                // Read strobe pulses low when software reads the pin state
                if (wb_req && !wb_we_i && wb_adr_i == `UBBP_REG_DATA)
                    rd_n <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        rd_n <= 1'b0;
                        wr_n <= 1'b1;
                        // Wait for a byte and room for its sample
                        if (data_new && fifo_in_ready && baud_tick) begin
                            cap_byte <= pin_sync;
                            cap_push <= 1'b1;
                            state    <= ST_RDOFF;
                        end
                    end
                    ST_RDOFF: begin
                        rd_n  <= 1'b1;
                        if (baud_tick)
                            state <= ST_DRIVE;
                    end
                    ST_DRIVE: begin
                        rd_n     <= 1'b0;
                        out_val  <= data_reg;
                        data_new <= 1'b0;
                        state    <= ST_SETUP;
                    end
                    ST_SETUP: begin
                        // One paced state lets the data settle before the write strobe
                        if (baud_tick) begin
                            wr_n  <= 1'b0;
                            state <= ST_WRACT;
                        end
                    end
                    ST_WRACT: begin
                        if (baud_tick) begin
                            wr_n  <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
            // A fresh write sets the pending flag; this wins over the clear above
            if (wr_data && (mode_async || mode_sync)) begin
                data_reg <= wb_dat_i[7:0];
                data_new <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample FIFO: drains only when software reads it or sync mode is off, so it really fills
    ubbp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (2)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .flush     (~mode_sync),
        .in_data   (cap_byte),
        .in_valid  (cap_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers and strobe routing, all registered
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_out     <= 8'h00;
            bus_oe      <= 8'h00;
            status_wr_n <= 1'b1;
            status_rd_n <= 1'b1;
            alt_wr_n    <= 1'b1;
            alt_rd_n    <= 1'b1;
        end else begin
            bus_out     <= out_val & dir;
            bus_oe      <= (mode_async || mode_sync) ? dir : 8'h00;
            status_wr_n <= strobe_alt | wr_n;
            status_rd_n <= strobe_alt | rd_n;
            alt_wr_n    <= ~strobe_alt | wr_n;
            alt_rd_n    <= ~strobe_alt | rd_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake input: falling edge resumes when suspended with wakeup enabled, flushes transmit when not suspended
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resume_req <= 1'b0;
            flush_tx   <= 1'b0;
        end else begin
            resume_req <= wake_fall & susp_sr[1] & wake_en;
            flush_tx   <= wake_fall & ~susp_sr[1];
        end
    end
endmodule // ubbp_port

// ===== ubbp_port_sva.sv
// Checker for the bit-bang port: bus answers, strobe pairs, wake pulses.
// Assumes it is bound onto ubbp_port; one clock, asynchronous active-low reset.
`timescale 1ns/10ps
module ubbp_port_sva (
    input wire       clk,
    input wire       resetn,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_ack_o,
    input wire       wb_err_o,
    input wire [7:0] bus_out,
    input wire [7:0] bus_oe,
    input wire       status_wr_n,
    input wire       status_rd_n,
    input wire       alt_wr_n,
    input wire       alt_rd_n,
    input wire       send_now_wake_in,
    input wire       resume_req,
    input wire       flush_tx
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    // Named steps of a bus request and of a wake event
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_wake_fall;
        $fell(send_now_wake_in);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    AST_BUS_ANSWER: assert property (s_req |=> (wb_ack_o || wb_err_o))
        else $error("bus request not answered in one cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_OUT_MASKED: assert property ($changed(bus_out) |-> (bus_out & ~bus_oe) == 8'h00)
        else $error("data shown on a line that is not an output");
    // Only one pin pair may carry strobes at a time
    AST_PAIR_EXCL: assert property (!((!status_wr_n || !status_rd_n) && (!alt_wr_n || !alt_rd_n)))
        else $error("both strobe pairs active together");
    // Write strobe spans a whole tick period; the check asks for at least three clocks here
    AST_WR_WIDTH: assert property ($fell(status_wr_n) |-> !status_wr_n [*3])
        else $error("write strobe shorter than a tick period");
    AST_WAKE_ACT: assert property (s_wake_fall |-> ##[1:8] (resume_req || flush_tx))
        else $error("wake edge gave no resume or flush");
    AST_WAKE_EXCL: assert property (!(resume_req && flush_tx))
        else $error("resume and flush at once");
    AST_RESUME_PULSE: assert property (resume_req |=> !resume_req)
        else $error("resume request longer than one cycle");
    AST_FLUSH_PULSE: assert property (flush_tx |=> !flush_tx)
        else $error("flush longer than one cycle");
endmodule // ubbp_port_sva

bind ubbp_port ubbp_port_sva u_sva (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .bus_out(bus_out), .bus_oe(bus_oe),
    .status_wr_n(status_wr_n), .status_rd_n(status_rd_n), .alt_wr_n(alt_wr_n), .alt_rd_n(alt_rd_n),
    .send_now_wake_in(send_now_wake_in), .resume_req(resume_req), .flush_tx(flush_tx));

// ===== ubbp_ext_logic.sv
// Model of the external logic clocked by the bit-bang write strobe.
// Assumes the pins carry pull-ups, so released lines read high.
`timescale 1ns/10ps
module ubbp_ext_logic (
    input  wire [7:0]  bus_out,
    input  wire [7:0]  bus_oe,
    input  wire        wr_n,
    output wire [7:0]  bus_in,
    output reg  [7:0]  last_byte,
    output reg  [15:0] wr_count
);
    // Undriven lines float to the pull-up level, never to a stale value
    assign bus_in = (bus_out & bus_oe) | ~bus_oe;
    initial begin
        last_byte = 8'h00;
        wr_count  = 16'h0000;
    end
    // Latch on the trailing strobe edge, where data has had its setup time
    always @(posedge wr_n) begin
        last_byte <= bus_in;
        wr_count  <= wr_count + 16'h0001;
    end
endmodule // ubbp_ext_logic

// ===== ubbp_port_bench.sv
// Self-checking bench for the bit-bang port: async, sync, refusals, wake.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/10ps
`include "ubbp_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("Error at %0t ns: got %h expected %h", $time, g, e); end end
module ubbp_port_bench;
    reg         clk, resetn, wb_we_i, wb_cyc_i, wb_stb_i, send_now_wake_in, power_on_state_n;
    reg  [3:0]  wb_adr_i, wb_sel_i;
    reg  [31:0] wb_dat_i, q;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o, wb_err_o, status_wr_n, status_rd_n, alt_wr_n, alt_rd_n, resume_req, flush_tx;
    wire [7:0]  bus_in, bus_out, bus_oe, ext_byte;
    wire [15:0] ext_count;
    reg  [15:0] seed, cnt;
    reg  [7:0]  dir, d;
    reg  [7:0]  b [0:4];
    reg         err;
    integer     num_errors = 0, samples_checked = 0, n_resume = 0, n_flush = 0, n_rd = 0, i;
    ////////////////////////////////////////////////////////////////////////
    // Short tick so that the sync engine runs in few cycles
    ubbp_port #(.FIFO_DEPTH(4), .BAUD_DIV(16'h0004)) u_dut (.clk(clk), .resetn(resetn), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .bus_in(bus_in), .bus_out(bus_out),
        .bus_oe(bus_oe), .status_wr_n(status_wr_n), .status_rd_n(status_rd_n), .alt_wr_n(alt_wr_n),
        .alt_rd_n(alt_rd_n), .send_now_wake_in(send_now_wake_in), .power_on_state_n(power_on_state_n),
        .resume_req(resume_req), .flush_tx(flush_tx));
    ubbp_ext_logic u_ext (.bus_out(bus_out), .bus_oe(bus_oe), .wr_n(status_wr_n & alt_wr_n),
        .bus_in(bus_in), .last_byte(ext_byte), .wr_count(ext_count));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Count one-cycle wake outputs and low cycles of the status read strobe
    always @(posedge clk) begin
        if (resume_req === 1'b1) n_resume++;
        if (flush_tx === 1'b1) n_flush++;
        if (status_rd_n === 1'b0) n_rd++;
    end
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Level seen on the pins for a byte and a direction mask
    function [7:0] pin_exp(input [7:0] dv, input [7:0] dr);
        pin_exp = (dv & dr) | ~dr;
    endfunction
    // Classic single cycle; held until ack or err is sampled
    task wb(input [3:0] a, input w, input [31:0] dt);
        integer n;
        begin
            @(posedge clk);
            wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_adr_i <= a; wb_we_i <= w; wb_dat_i <= dt;
            n = 0;
            do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
            q = wb_dat_o;
            err = wb_err_o;
            `CHK(n < 50, 1'b1)
            wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
        end
    endtask
    // Wait for one full write strobe on the chosen pair
    task wait_wr(input alt);
        integer n;
        begin
            n = 0;
            while ((alt ? alt_wr_n : status_wr_n) !== 1'b0 && n < 200) begin @(posedge clk); n++; end
            while ((alt ? alt_wr_n : status_wr_n) !== 1'b1 && n < 400) begin @(posedge clk); n++; end
            `CHK(n < 400, 1'b1)
        end
    endtask
    task wake_pulse;
        begin
            @(posedge clk); send_now_wake_in <= 1'b0;
            repeat (6) @(posedge clk); send_now_wake_in <= 1'b1;
            repeat (12) @(posedge clk);
        end
    endtask
    task print_verdict;
        begin
            $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0; wb_we_i = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_adr_i = 4'h0;
        wb_sel_i = 4'hf; wb_dat_i = 32'h0; send_now_wake_in = 1'b1; power_on_state_n = 1'b0;
        seed = 16'he565;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        `CHK(bus_oe, 8'h00)
        `CHK({status_wr_n, status_rd_n, alt_wr_n, alt_rd_n}, 4'hf)
        // Async mode, status pins, random directions and bytes
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed); dir = (i == 0) ? 8'hff : seed[7:0];
            seed = lfsr(seed); d = seed[7:0];
            wb(`UBBP_REG_DIR, 1'b1, {24'h0, dir});
            wb(`UBBP_REG_MODE, 1'b1, {24'h0, `UBBP_MODE_ASYNC});
            wb(`UBBP_REG_DATA, 1'b1, {24'h0, d});
            wait_wr(1'b0);
            `CHK(bus_oe, dir)
            `CHK(bus_out, d & dir)
            `CHK(ext_byte, pin_exp(d, dir))
        end
        cnt = ext_count;
        repeat (40) @(posedge clk);
        `CHK(bus_out, d & dir)
        `CHK(ext_count, cnt)
        cnt = n_rd;
        wb(`UBBP_REG_DATA, 1'b0, 32'h0);
        `CHK(q[7:0], pin_exp(d, dir))
        // Read strobe shows on the status pin one registered cycle later
        repeat (3) @(posedge clk);
        `CHK(n_rd - cnt, 1)
        wb(4'h2, 1'b1, 32'h0000_00a5);
        `CHK(err, 1'b1)
        wb(`UBBP_REG_MODE, 1'b1, {24'h0, `UBBP_MODE_RESET});
        repeat (3) @(posedge clk);
        `CHK(bus_oe, 8'h00)
        // Channel B with the isolated primary mode stays out of bit-bang
        wb(`UBBP_REG_DIR, 1'b1, 32'h0000_00ff);
        wb(`UBBP_REG_MODE, 1'b1, 32'h0000_0501);
        wb(`UBBP_REG_DATA, 1'b1, 32'h0000_003c);
        repeat (20) @(posedge clk);
        `CHK(bus_oe, 8'h00)
        $display("Test async done");
        // Second reset, then sync mode on the alternate pair
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        wb(`UBBP_REG_DIR, 1'b1, 32'h0000_00ff);
        wb(`UBBP_REG_MODE, 1'b1, 32'h0000_0204);
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed); b[i] = seed[7:0];
            wb(`UBBP_REG_DATA, 1'b1, {24'h0, b[i]});
            wait_wr(1'b1);
            `CHK(bus_out, b[i])
        end
        `CHK(status_wr_n, 1'b1)
        // Sample store is full now, so the fifth byte must wait
        seed = lfsr(seed); b[4] = seed[7:0];
        wb(`UBBP_REG_DATA, 1'b1, {24'h0, b[4]});
        repeat (40) @(posedge clk);
        `CHK(bus_out, b[3])
        wb(`UBBP_REG_SAMPLE, 1'b0, 32'h0);
        `CHK(q[8:0], 9'h100)
        wait_wr(1'b1);
        `CHK(bus_out, b[4])
        for (i = 0; i < 4; i++) begin
            wb(`UBBP_REG_SAMPLE, 1'b0, 32'h0);
            `CHK(q[8:0], {1'b1, b[i]})
        end
        wb(`UBBP_REG_SAMPLE, 1'b0, 32'h0);
        `CHK(q[8], 1'b0)
        $display("Test sync done");
        // Wake input: suspended with wakeup on, then normal operation
        wb(`UBBP_REG_MODE, 1'b1, 32'h0000_0800);
        power_on_state_n <= 1'b1;
        wake_pulse;
        `CHK(n_resume, 1)
        `CHK(n_flush, 0)
        power_on_state_n <= 1'b0;
        wake_pulse;
        `CHK(n_flush, 1)
        `CHK(n_resume, 1)
        $display("Test wake done");
        print_verdict;
    end
endmodule // ubbp_port_bench
